// >>> hw/qc_top.sv
// quad 24-bit up/down counter with compare match and interval timer
// assumes a single 100 MHz mclk; pins arrive asynchronously
//
// What this block does
// - four independent 24-bit up/down counters, wrapping at all ones.
// - each counter decodes two-phase A/B inputs, up or down by phase.
// - per channel, software picks line-receiver or logic-level inputs.
// - count equal to compare value raises interrupt and one match pulse.
// - interval timer interrupts periodically, period 1 ms to 200 s.
// - one interrupt line for any channel match or timer expiry.
// - per-channel input filter, 0.1 us to 1056.1 us.
// - match pulse width 0 to 104.45 ms, one setting for all channels.
// - each channel has a readable general-purpose input, either source.
//
// The register addresses and the strobed register port were decided locally.
`include "qc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module qc_top #(
  parameter int CNT_W     = `QC_CNT_W,
  parameter int N_CH      = 4,
  parameter int MS_CYCLES = `QC_MS_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire logic [3:0]  lr_phase_a,
  input  wire logic [3:0]  lr_phase_b,
  input  wire logic [3:0]  lr_index_clear_input,
  input  wire logic [3:0]  lr_gp_in,
  input  wire logic [3:0]  ttl_phase_a,
  input  wire logic [3:0]  ttl_phase_b,
  input  wire logic [3:0]  ttl_index_clear_input,
  input  wire logic [3:0]  ttl_gp_in,
  output logic      [3:0]  match_out,
  output logic             irq
);
  import qc_pkg::*;

  localparam int FW = `QC_FILT_W;
  localparam int WW = `QC_WID_W;
  localparam int PW = `QC_PER_W;
  localparam int NIRQ = N_CH + 1;

  generate
    if (N_CH != 4) begin : g_bad_nch
      $error("qc_top: register map serves exactly four channels");
    end
    if (CNT_W < 2 || CNT_W > 32) begin : g_bad_cw
      $error("qc_top: counter width must be 2 to 32 bits");
    end
    if (MS_CYCLES < 2) begin : g_bad_ms
      $error("qc_top: millisecond prescale must be at least 2");
    end
  endgenerate

  // pin synchronisers: three stages, a change is believed once 2 and 3 agree
  logic [31:0] pin_raw;
  logic [31:0] s1_q;
  logic [31:0] s2_q;
  logic [31:0] s3_q;
  logic [31:0] pin_q;
  logic [31:0] agree;

  assign pin_raw = {ttl_gp_in, ttl_index_clear_input, ttl_phase_b,
                    ttl_phase_a, lr_gp_in, lr_index_clear_input,
                    lr_phase_b, lr_phase_a};
  assign agree = ~(s2_q ^ s3_q);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s1_q  <= 32'h0;
      s2_q  <= 32'h0;
      s3_q  <= 32'h0;
      pin_q <= 32'h0;
    end else if (ce) begin
      s1_q  <= pin_raw;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      pin_q <= (s3_q & agree) | (pin_q & ~agree);
    end
  end

  // per-channel settings
  logic [N_CH-1:0] sel_ttl_q;
  logic [N_CH-1:0] updn_q;
  logic [N_CH-1:0] clr_en_q;
  logic [FW-1:0]   filt_q [N_CH];
  logic [CNT_W-1:0] cmp_q [N_CH];
  logic [N_CH-1:0] load;
  logic [CNT_W-1:0] count [N_CH];
  logic [N_CH-1:0] mev;
  logic [N_CH-1:0] mout;
  logic [N_CH-1:0] gpin;

  // global settings
  logic          tmr_en_q;
  logic [PW-1:0] tmr_per_q;
  logic [WW-1:0] mwidth_q;
  logic [NIRQ-1:0] stat_q;
  logic [NIRQ-1:0] mask_q;
  logic [31:0]   rdata_q;

  // register decode
  logic          ch_area;
  logic [1:0]    ch_sel;
  logic [3:0]    ch_ofs;
  logic [FW-1:0] filt_in;
  logic [WW-1:0] wid_in;
  logic [PW-1:0] per_in;

  assign ch_area = (addr < `QC_CH_AREA_END);
  assign ch_sel  = addr[5:4];
  assign ch_ofs  = addr[3:0];

  // filter and width clamp on wdata[15:0], period on all 32 bits, so the hardware never runs off its span
  assign filt_in = (wdata[15:0] > 16'(`QC_FILT_MAX)) ?
                   `QC_FILT_MAX : wdata[FW-1:0];
  assign wid_in  = (wdata[15:0] > 16'(`QC_WID_MAX)) ?
                   `QC_WID_MAX : wdata[WW-1:0];
  assign per_in  = (wdata[31:0] > 32'(`QC_PER_MAX)) ? `QC_PER_MAX :
                   (wdata[31:0] < 32'(`QC_PER_MIN)) ? `QC_PER_MIN :
                   wdata[PW-1:0];

  // each channel's settings touch only that channel
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sel_ttl_q <= '0;
      updn_q    <= '0;
      clr_en_q  <= '0;
      for (int i = 0; i < N_CH; i++) begin
        filt_q[i] <= '0;
        cmp_q[i]  <= '0;
      end
    end else if (ce && wr && ch_area) begin
      case (ch_ofs)
        `QC_OFS_CTRL: begin
          sel_ttl_q[ch_sel] <= wdata[`QC_BIT_SEL_TTL];
          updn_q[ch_sel]    <= wdata[`QC_BIT_UPDN];
          clr_en_q[ch_sel]  <= wdata[`QC_BIT_CLR_EN];
        end
        `QC_OFS_FILT: filt_q[ch_sel] <= filt_in;
        `QC_OFS_CMP:  cmp_q[ch_sel]  <= wdata[CNT_W-1:0];
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    load = '0;
    if (wr && ch_area && ch_ofs == `QC_OFS_COUNT) begin
      load[ch_sel] = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tmr_en_q  <= 1'b0;
      tmr_per_q <= `QC_PER_MIN;
      mwidth_q  <= '0;
      mask_q    <= '0;
    end else if (ce && wr) begin
      case (addr)
        `QC_OFS_TMR_CTRL: tmr_en_q  <= wdata[`QC_BIT_TMR_EN];
        `QC_OFS_TMR_PER:  tmr_per_q <= per_in;
        `QC_OFS_MWIDTH:   mwidth_q  <= wid_in;
        `QC_OFS_IRQ_MASK: mask_q    <= wdata[NIRQ-1:0];
        default: begin
        end
      endcase
    end
  end

  // shared tick generators: 0.1 us filter step, 10 us width step
  logic [3:0]  fpre_q;
  logic [9:0]  wpre_q;
  logic        tick_f;
  logic        tick_w;
  localparam logic [3:0] FPRE_LAST = 4'(`QC_FILT_STEP_CYC - 1);
  localparam logic [9:0] WPRE_LAST = 10'(`QC_WSTEP_CYC - 1);

  // prescalers are sized for the default clock; refuse one they cannot count
  generate
    if (`QC_FILT_STEP_CYC < 1 ||
        `QC_FILT_STEP_CYC > 2 ** $bits(fpre_q)) begin : g_bad_fpre
      $error("qc_top: filter step does not fit its prescaler");
    end
    if (`QC_WSTEP_CYC < 1 ||
        `QC_WSTEP_CYC > 2 ** $bits(wpre_q)) begin : g_bad_wpre
      $error("qc_top: width step does not fit its prescaler");
    end
  endgenerate

  assign tick_f = (fpre_q == FPRE_LAST);
  assign tick_w = (wpre_q == WPRE_LAST);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fpre_q <= 4'h0;
      wpre_q <= 10'h000;
    end else if (ce) begin
      fpre_q <= tick_f ? 4'h0 : fpre_q + 4'h1;
      wpre_q <= tick_w ? 10'h000 : wpre_q + 10'h001;
    end
  end

  // interval timer; writing control or period restarts it
  // a restart drops the partial interval, so no early event follows a write
  logic [31:0]   mpre_q;
  logic [PW-1:0] tcnt_q;
  logic          tick_ms;
  logic          tmr_ev;
  logic          tmr_wr;

  assign tick_ms = (mpre_q == 32'(MS_CYCLES - 1));
  assign tmr_ev  = tmr_en_q && tick_ms && (tcnt_q >= tmr_per_q - 1'b1);
  assign tmr_wr  = wr && (addr == `QC_OFS_TMR_CTRL ||
                          addr == `QC_OFS_TMR_PER);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mpre_q <= 32'h0;
      tcnt_q <= '0;
    end else if (ce) begin
      if (tmr_wr || !tmr_en_q) begin
        mpre_q <= 32'h0;
        tcnt_q <= '0;
      end else if (tick_ms) begin
        mpre_q <= 32'h0;
        tcnt_q <= tmr_ev ? '0 : tcnt_q + 1'b1;
      end else begin
        mpre_q <= mpre_q + 32'h1;
      end
    end
  end

  // channels
  genvar g;
  generate
    for (g = 0; g < N_CH; g++) begin : g_ch
      qc_chan_if #(.CW(CNT_W), .FW(FW), .WW(WW)) chi ();
      logic src;
      assign src = sel_ttl_q[g];
      // source choice is per channel, after synchronising both paths
      assign chi.a = src ? pin_q[16+g] : pin_q[g];
      assign chi.b = src ? pin_q[20+g] : pin_q[4+g];
      assign chi.z = src ? pin_q[24+g] : pin_q[8+g];
      assign gpin[g] = src ? pin_q[28+g] : pin_q[12+g];
      assign chi.tick_f   = tick_f;
      assign chi.tick_w   = tick_w;
      assign chi.mode     = updn_q[g] ? QC_MODE_UPDN : QC_MODE_QUAD;
      assign chi.clr_en   = clr_en_q[g];
      assign chi.filt     = filt_q[g];
      assign chi.cmp      = cmp_q[g];
      assign chi.width    = mwidth_q;
      assign chi.load     = load[g] && ce;
      assign chi.load_val = wdata[CNT_W-1:0];
      assign count[g]     = chi.count;
      assign mev[g]       = chi.match_ev;
      assign mout[g]      = chi.match_out;

      qc_chan #(.CW(CNT_W), .FW(FW), .WW(WW)) u_chan (
        .mclk (mclk),
        .rst  (rst),
        .ce   (ce),
        .ch   (chi.chan)
      );
    end
  endgenerate

  // sticky status; a new event beats a clear in the same cycle
  logic [NIRQ-1:0] ev;
  logic [NIRQ-1:0] w1c;

  assign ev  = {tmr_ev, mev};
  assign w1c = (wr && addr == `QC_OFS_IRQ_STAT) ? wdata[NIRQ-1:0] : '0;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stat_q <= '0;
    end else if (ce) begin
      stat_q <= (stat_q & ~w1c) | ev;
    end
  end

  // mask is read before its own write lands, so masking lags one cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(((stat_q & ~w1c) | ev) & mask_q);
    end
  end

  assign match_out = mout;

  // read data stands only in the cycle after the strobe
  logic [31:0] rmux;

  always_comb begin
    rmux = 32'h0;
    if (ch_area) begin
      case (ch_ofs)
        `QC_OFS_CTRL: begin
          rmux[`QC_BIT_SEL_TTL] = sel_ttl_q[ch_sel];
          rmux[`QC_BIT_UPDN]    = updn_q[ch_sel];
          rmux[`QC_BIT_CLR_EN]  = clr_en_q[ch_sel];
        end
        `QC_OFS_FILT:  rmux[FW-1:0]    = filt_q[ch_sel];
        `QC_OFS_CMP:   rmux[CNT_W-1:0] = cmp_q[ch_sel];
        `QC_OFS_COUNT: rmux[CNT_W-1:0] = count[ch_sel];
        default:       rmux = 32'h0;
      endcase
    end else begin
      case (addr)
        `QC_OFS_TMR_CTRL: rmux[`QC_BIT_TMR_EN] = tmr_en_q;
        `QC_OFS_TMR_PER:  rmux[PW-1:0]   = tmr_per_q;
        `QC_OFS_MWIDTH:   rmux[WW-1:0]   = mwidth_q;
        `QC_OFS_IRQ_STAT: rmux[NIRQ-1:0] = stat_q;
        `QC_OFS_IRQ_MASK: rmux[NIRQ-1:0] = mask_q;
        `QC_OFS_GPIN:     rmux[N_CH-1:0] = gpin;
        default:          rmux = 32'h0;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_q <= 32'h0;
    end else if (ce) begin
      rdata_q <= rd ? rmux : 32'h0;
    end
  end

  assign rdata = rdata_q;
endmodule
`default_nettype wire

// >>> hw/qc_defs.svh
// constants of the quad up/down counter: timing, field layout, offsets
// assumes a 100 MHz mclk; included by bare name from hw/
`ifndef QC_DEFS_SVH
`define QC_DEFS_SVH
`define QC_CLK_NS        10
`define QC_FILT_STEP_NS  100
`define QC_WSTEP_NS      10000
`define QC_MS_NS         1000000
`define QC_FILT_STEP_CYC (`QC_FILT_STEP_NS / `QC_CLK_NS)
`define QC_WSTEP_CYC     (`QC_WSTEP_NS / `QC_CLK_NS)
`define QC_MS_CYC        (`QC_MS_NS / `QC_CLK_NS)
`define QC_CNT_W         24
`define QC_FILT_W        14
`define QC_WID_W         14
`define QC_PER_W         18
`define QC_FILT_MAX      14'h2940
`define QC_WID_MAX       14'h28cd
`define QC_PER_MIN       18'h00001
`define QC_PER_MAX       18'h30d40
`define QC_CH_STRIDE     8'h10
`define QC_OFS_CTRL      4'h0
`define QC_OFS_FILT      4'h4
`define QC_OFS_CMP       4'h8
`define QC_OFS_COUNT     4'hc
`define QC_OFS_TMR_CTRL  8'h40
`define QC_OFS_TMR_PER   8'h44
`define QC_OFS_MWIDTH    8'h48
`define QC_OFS_IRQ_STAT  8'h4c
`define QC_OFS_IRQ_MASK  8'h50
`define QC_OFS_GPIN      8'h54
`define QC_CH_AREA_END   8'h40
`define QC_BIT_SEL_TTL   0
`define QC_BIT_UPDN      1
`define QC_BIT_CLR_EN    2
`define QC_BIT_TMR_EN    0
`define QC_IRQ_TMR_BIT   4
`endif

// >>> hw/qc_pkg.sv
// types of the quad up/down counter
// assumes nothing beyond a SystemVerilog compiler
package qc_pkg;
  typedef enum logic [1:0] {
    QC_MODE_QUAD = 2'b01,
    QC_MODE_UPDN = 2'b10
  } qc_mode_type;
endpackage

// >>> hw/qc_chan_if.sv
// carrier between the register file and one counter channel
// assumes qc_pkg compiled first
`timescale 1ns/1ps
`default_nettype none
interface qc_chan_if #(
  parameter int CW = 24,
  parameter int FW = 14,
  parameter int WW = 14
);
  logic               a;
  logic               b;
  logic               z;
  logic               tick_f;
  logic               tick_w;
  qc_pkg::qc_mode_type mode;
  logic               clr_en;
  logic [FW-1:0]      filt;
  logic [CW-1:0]      cmp;
  logic [WW-1:0]      width;
  logic               load;
  logic [CW-1:0]      load_val;
  logic [CW-1:0]      count;
  logic               match_ev;
  logic               match_out;
  modport cfg  (output a, b, z, tick_f, tick_w, mode, clr_en, filt, cmp,
                width, load, load_val, input count, match_ev, match_out);
  modport chan (input a, b, z, tick_f, tick_w, mode, clr_en, filt, cmp,
                width, load, load_val, output count, match_ev, match_out);
endinterface
`default_nettype wire

// >>> hw/qc_chan.sv
// one counter channel: input filter, decoder, counter, compare, match pulse
// assumes inputs already synchronised to mclk, ticks one cycle long
`timescale 1ns/1ps
`default_nettype none
module qc_chan #(
  parameter int CW = 24,
  parameter int FW = 14,
  parameter int WW = 14
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  qc_chan_if.chan  ch
);
  import qc_pkg::*;
  logic [2:0]    raw;
  logic [2:0]    flt_q;
  logic [2:0]    prv_q;
  logic [FW-1:0] fcnt_q [3];
  logic [CW-1:0] count_q;
  logic          eq_q;
  logic [WW-1:0] wcnt_q;
  logic          mout_q;
  logic          mev_q;
  logic          up;
  logic          dn;
  logic          eq;

  assign raw = {ch.z, ch.b, ch.a};

  // a level must hold for filt+1 filter ticks before it is believed
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flt_q <= 3'h0;
      for (int i = 0; i < 3; i++) fcnt_q[i] <= '0;
    end else if (ce) begin
      for (int i = 0; i < 3; i++) begin
        if (raw[i] == flt_q[i]) begin
          fcnt_q[i] <= '0;
        end else if (ch.tick_f) begin
          if (fcnt_q[i] >= ch.filt) begin
            flt_q[i]  <= raw[i];
            fcnt_q[i] <= '0;
          end else begin
            fcnt_q[i] <= fcnt_q[i] + 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prv_q <= 3'h0;
    end else if (ce) begin
      prv_q <= flt_q;
    end
  end

  // x4 decode; a double step is a fault and is dropped
  always_comb begin
    up = 1'b0;
    dn = 1'b0;
    case (ch.mode)
      QC_MODE_QUAD: begin
        if ((flt_q[0] ^ prv_q[0]) != (flt_q[1] ^ prv_q[1])) begin
          up = flt_q[0] ^ prv_q[1];
          dn = ~(flt_q[0] ^ prv_q[1]);
        end
      end
      QC_MODE_UPDN: begin
        up = flt_q[0] & ~prv_q[0];
        dn = flt_q[1] & ~prv_q[1];
      end
      default: begin
        up = 1'b0;
        dn = 1'b0;
      end
    endcase
  end

  // wraps modulo 2**CW; up and down together cancel
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      count_q <= '0;
    end else if (ce) begin
      if (ch.load) begin
        count_q <= ch.load_val;
      end else if (ch.clr_en && flt_q[2] && !prv_q[2]) begin
        count_q <= '0;
      end else if (up && !dn) begin
        count_q <= count_q + 1'b1;
      end else if (dn && !up) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

  assign eq = (count_q == ch.cmp);

  // only the arrival at the compare value counts, not dwelling on it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      eq_q   <= 1'b1;
      mev_q  <= 1'b0;
      wcnt_q <= '0;
      mout_q <= 1'b0;
    end else if (ce) begin
      eq_q  <= eq;
      mev_q <= eq && !eq_q;
      if (mev_q) begin
        wcnt_q <= ch.width;
        mout_q <= (ch.width != '0);
      end else if (ch.tick_w && wcnt_q != '0) begin
        wcnt_q <= wcnt_q - 1'b1;
        mout_q <= (wcnt_q != {{(WW-1){1'b0}}, 1'b1});
      end
    end
  end

  assign ch.count     = count_q;
  assign ch.match_ev  = mev_q;
  assign ch.match_out = mout_q;
endmodule
`default_nettype wire

// >>> dv/qc_enc_model.sv
// two-phase encoder model: one quadrature step per request
// assumes requests spaced wider than the design's input filter time
`timescale 1ns/1ps
`default_nettype none
module qc_enc_model (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic step,
  input  wire logic up,
  output logic      a,
  output logic      b
);
  logic [1:0] ph_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      ph_q <= 2'h0;
    else if (step)
      ph_q <= up ? ph_q + 2'h1 : ph_q - 2'h1;
  end
  // gray order, so only one phase moves per step
  assign a = ph_q[1] ^ ph_q[0];
  assign b = ph_q[1];
endmodule
`default_nettype wire

// >>> dv/qc_top_checker.sv
// port checker for qc_top: bus answers, interrupt line, match pin
// assumes one mclk domain and rst asynchronous, active high
`include "qc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module qc_top_checker (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic [3:0]  match_out,
  input wire logic        irq
);
  logic [13:0] mw_q;
  logic [31:0] hi_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // width shadow ignores clamping; it loosens the bound, but can tighten it when wdata bit 14 or 15 is set
  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      mw_q <= '0;
    else if (ce && wr && addr == `QC_OFS_MWIDTH)
      mw_q <= wdata[13:0];
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      hi_q <= '0;
    else if (ce)
      hi_q <= match_out[0] ? hi_q + 32'h1 : 32'h0;
  end
  property p_rdata_idle;
    $past(ce) && !$past(rd) |-> rdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("rdata not zero outside read answer");
  property p_unmapped;
    ce && rd && addr == 8'h60 |=> rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_gpin_width;
    ce && rd && addr == `QC_OFS_GPIN |=> rdata[31:4] == 28'h0;
  endproperty
  a_gpin_width: assert property (p_gpin_width)
    else $error("gp input read has upper bits");
  property p_count_width;
    ce && rd && addr < 8'h40 && addr[3:0] == 4'hc |=> rdata[31:24] == 8'h0;
  endproperty
  a_count_width: assert property (p_count_width)
    else $error("count wider than 24 bits");
  property p_mask_off;
    ce && wr && addr == `QC_OFS_IRQ_MASK && wdata[4:0] == 5'h0 |=> ##1 !irq;
  endproperty
  a_mask_off: assert property (p_mask_off)
    else $error("irq high with all sources masked");
  property p_irq_fall;
    $fell(irq) |-> $past(ce && wr && addr == `QC_OFS_IRQ_STAT)
      || $past(ce && wr && addr == `QC_OFS_IRQ_MASK, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("irq dropped without status or mask write");
  property p_ce_hold;
    !ce |=> $stable(irq) && $stable(match_out);
  endproperty
  a_ce_hold: assert property (p_ce_hold)
    else $error("outputs moved with clock enable low");
  property p_match_len;
    match_out[0] |-> hi_q <= mw_q * `QC_WSTEP_CYC + 2;
  endproperty
  a_match_len: assert property (p_match_len)
    else $error("match pulse longer than width setting");
  property p_match_off;
    match_out[0] |-> mw_q != 14'h0;
  endproperty
  a_match_off: assert property (p_match_off)
    else $error("match pulse with zero width");
endmodule
bind qc_top qc_top_checker u_chk (.mclk(mclk), .rst(rst), .ce(ce),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .match_out(match_out), .irq(irq));
`default_nettype wire

// >>> dv/qc_top_bench.sv
// self-checking bench for qc_top: registers, counting, match, timer
// assumes qc_enc_model drives channel 0 line-receiver phases
`timescale 1ns/1ps
`default_nettype none
module qc_top_bench;
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] e;
  } qc_row_type;
  logic        mclk, rst, ce, wr, rd, irq, step, up, enc_a, enc_b;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata;
  logic [3:0]  ta, tb, tz, lr_gp, ttl_gp, lr_z, match_out;
  int          err_total, check_count, cyc, t0;
  qc_row_type  rows [8] = '{
    '{8'h04, 32'h0000ffff, 32'h00002940}, '{8'h34, 32'h1, 32'h1},
    '{8'h18, 32'hffffffff, 32'h00ffffff}, '{8'h2c, 32'h123456, 32'h123456},
    '{8'h44, 32'h0, 32'h1}, '{8'h44, 32'h0003ffff, 32'h00030d40},
    '{8'h48, 32'h3fff, 32'h28cd}, '{8'h60, 32'hffffffff, 32'h0}};
  qc_enc_model u_enc (.mclk(mclk), .rst(rst), .step(step), .up(up),
    .a(enc_a), .b(enc_b));
  qc_top #(.MS_CYCLES(20)) DUT (.mclk(mclk), .rst(rst), .ce(ce),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .lr_phase_a({lr_z[3:1], enc_a}), .lr_phase_b({lr_z[3:1], enc_b}),
    .lr_index_clear_input(lr_z), .lr_gp_in(lr_gp),
    .ttl_phase_a(ta), .ttl_phase_b(tb), .ttl_index_clear_input(tz),
    .ttl_gp_in(ttl_gp), .match_out(match_out), .irq(irq));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) cyc <= cyc + 1;
  task automatic finish_test;
    if (err_total == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd   <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), e, rdata);
  endtask
  // spacing well above filter, synchroniser and count latency
  task automatic enc(input logic u, input int n);
    repeat (n) begin
      @(posedge mclk);
      step <= 1'b1;
      up   <= u;
      @(posedge mclk);
      step <= 1'b0;
      repeat (40) @(posedge mclk);
    end
  endtask
  task automatic tp(input int k);
    @(posedge mclk);
    {ta[1], tb[1], tz[1]} <= 3'b100 >> k;
    repeat (40) @(posedge mclk);
    {ta[1], tb[1], tz[1]} <= 3'b000;
    repeat (40) @(posedge mclk);
  endtask
  task automatic wait_irq;
    #1;
    for (int i = 0; i < 300 && irq !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    if (irq !== 1'b1) begin
      err_total++;
      finish_test;
    end
  endtask
  initial begin
    {rst, ce, wr, rd, step, up} = 6'b110000;
    {addr, wdata, ta, tb, tz, lr_gp, ttl_gp, lr_z} = '0;
    {err_total, check_count, cyc, t0} = '0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    rd_chk(8'h44, 32'h1);
    rd_chk(8'h0c, 32'h0);
    foreach (rows[i]) begin
      wr_reg(rows[i].a, rows[i].d);
      rd_chk(rows[i].a, rows[i].e);
    end
    wr_reg(8'h48, 32'h0);
    wr_reg(8'h04, 32'h0);
    enc(1'b1, 4);
    rd_chk(8'h0c, 32'h4);
    enc(1'b0, 6);
    rd_chk(8'h0c, 32'hfffffe);
    enc(1'b1, 2);
    rd_chk(8'h0c, 32'h0);
    wr_reg(8'h00, 32'h1);
    enc(1'b1, 4);
    rd_chk(8'h0c, 32'h0);
    wr_reg(8'h00, 32'h0);
    wr_reg(8'h4c, 32'h1f);
    wr_reg(8'h48, 32'h2);
    wr_reg(8'h08, 32'h2);
    wr_reg(8'h50, 32'h1);
    enc(1'b1, 2);
    #1;
    chk("match_out", 32'h1, {28'h0, match_out});
    chk("irq", 32'h1, {31'h0, irq});
    rd_chk(8'h4c, 32'h1);
    rd_chk(8'h2c, 32'h123456);
    wr_reg(8'h4c, 32'h1);
    @(posedge mclk);
    #1;
    chk("irq", 32'h0, {31'h0, irq});
    repeat (2100) @(posedge mclk);
    chk("match_out", 32'h0, {28'h0, match_out});
    wr_reg(8'h10, 32'h7);
    tp(0);
    tp(0);
    tp(0);
    tp(1);
    rd_chk(8'h1c, 32'h2);
    tp(2);
    rd_chk(8'h1c, 32'h0);
    lr_gp  <= 4'h5;
    ttl_gp <= 4'ha;
    repeat (40) @(posedge mclk);
    rd_chk(8'h54, 32'h7);
    wr_reg(8'h4c, 32'h1f);
    wr_reg(8'h50, 32'h10);
    wr_reg(8'h44, 32'h2);
    wr_reg(8'h40, 32'h1);
    wait_irq;
    t0 = cyc;
    wr_reg(8'h4c, 32'h10);
    wait_irq;
    chk("timer period", 32'd40, 32'(cyc - t0));
    wr_reg(8'h50, 32'h0);
    wr_reg(8'h40, 32'h0);
    @(posedge mclk);
    #1;
    chk("irq", 32'h0, {31'h0, irq});
    @(posedge mclk);
    ce <= 1'b0;
    wr_reg(8'h08, 32'h5);
    @(posedge mclk);
    ce <= 1'b1;
    rd_chk(8'h08, 32'h2);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd_chk(8'h44, 32'h1);
    finish_test;
  end
endmodule
`default_nettype wire
